//--- gcse_checker.sv
// Purpose: port-level checks on the status encoder
// Assumes: one clock domain, async active-low reset
// Notes: attached by bind below the module
`timescale 1ns/100ps
module gcse_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire gcse_pkg::gcse_cmd_type cmd_i,
    input wire logic [7:0] media_denied_code_i,
    input wire logic sts_valid_o,
    input wire gcse_pkg::gcse_status_type sts_o
);
    import gcse_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic abort_hit; // preempt-and-abort request
    logic early_hit; // any cause ranked above access denial
    assign abort_hit = cmd_i.preempted && (cmd_i.reservation_acquire_action == 3'b010);
    assign early_hit = abort_hit || cmd_i.ka_expired || cmd_i.san_forbidden;
    // command taken, then answer one cycle on
    sequence s_take;
        cmd_valid_i;
    endsequence
    sequence s_answer;
        ##1 sts_valid_o;
    endsequence
    chk_sts_latency: assert property (s_take |-> s_answer)
        else $error("status pulse missing after command");
    chk_no_spurious: assert property (!cmd_valid_i |=> !sts_valid_o)
        else $error("status pulse without command");
    chk_sts_hold: assert property (!cmd_valid_i |=> $stable(sts_o))
        else $error("status changed without command");
    chk_no_reserved: assert property (sts_valid_o |-> !(sts_o.code == 8'h17 ||
        (sts_o.code >= 8'h23 && sts_o.code <= 8'h7f))) else $error("reserved code seen");
    chk_intr_dnr: assert property (sts_valid_o && sts_o.code == 8'h21 |-> !sts_o.dnr)
        else $error("interrupted code with dnr set");
    chk_preempt_code: assert property (cmd_valid_i && abort_hit |=> sts_o.code == 8'h1b)
        else $error("preempt abort code wrong");
    chk_ka_expiry: assert property (cmd_valid_i && cmd_i.ka_expired && !abort_hit
        |=> sts_o.code == 8'h19) else $error("keep-alive expiry code wrong");
    chk_denied_code: assert property (cmd_valid_i && cmd_i.denied && !early_hit &&
        !cmd_i.media_access |=> sts_o == {8'h15, 1'b1}) else $error("denial code wrong");
    chk_media_code: assert property (cmd_valid_i && cmd_i.denied && !early_hit &&
        cmd_i.media_access |=> sts_o.code == $past(media_denied_code_i))
        else $error("media denial code wrong");
endmodule : gcse_checker

bind gcse_encoder gcse_checker u_gcse_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .media_denied_code_i(media_denied_code_i),
    .sts_valid_o(sts_valid_o), .sts_o(sts_o));

//--- gcse_encoder.sv
// Purpose: pick the generic status code and do-not-retry flag per command
// Assumes: one command condition set per cmd_valid_i pulse
// Notes: control and counters over axi4-lite
// Summary of operation
// - access-rights refusal reports 15h
// - media access denial uses dedicated code instead
// - invalid descriptor offset reports 16h
// - mixed host identifier widths report 18h
// - keep-alive expiry reports 19h
// - invalid keep-alive timeout reports 1Ah
// - preempt-and-abort reservation reports 1Bh
// - failed unrecovered sanitize reports 1Ch
// - function forbidden during sanitize reports 1Dh
// - bad descriptor granularity reports 1Eh
// - legacy mode reports 15h for granularity
// - unsupported queue in memory buffer reports 1Fh
// - revision 1.3 uses 1Fh only for sanitize
// - write-protected namespace reports 20h
// - interrupted code clears do-not-retry
// - interrupted code only with retry enabled
// - transient transport error reports 22h
// - 80h-BFh command set, C0h-FFh vendor
`timescale 1ns/100ps
module gcse_encoder (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // command conditions
    input wire logic cmd_valid_i,
    input wire gcse_pkg::gcse_cmd_type cmd_i,
    input wire logic [7:0] media_denied_code_i,
    // completion status
    output logic sts_valid_o,
    output gcse_pkg::gcse_status_type sts_o,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import gcse_pkg::*;

    logic [7:0] ctrl_q;        // control bits
    logic [15:0] cnt_q;        // completions issued
    logic [15:0] intr_cnt_q;   // interrupted completions
    gcse_status_type sts_q;    // registered status
    logic sts_valid_q;         // status strobe
    logic [7:0] aw_addr_q;     // captured write address
    logic aw_have_q;           // write address held
    logic [31:0] w_data_q;     // captured write data
    logic [3:0] w_strb_q;      // captured strobes
    logic w_have_q;            // write data held
    logic bvalid_q;            // write response pending
    logic [1:0] bresp_q;       // write response code
    logic rvalid_q;            // read data pending
    logic [31:0] rdata_q;      // read data
    logic [1:0] rresp_q;       // read response code
    gcse_status_type enc_d;    // combinational encoder result

    // reserved generic code test
    function automatic logic gcse_is_reserved(input logic [7:0] c);
        gcse_is_reserved = (c == GCSE_SC_RSVD_17) ||
            (c >= GCSE_SC_RSVD_LO && c <= GCSE_SC_RSVD_HI);
    endfunction : gcse_is_reserved

    // decoded control
    logic are_on;
    logic legacy;
    logic rev13;
    logic gran_bad;
    logic ka_bad;
    assign are_on = (ctrl_q[GCSE_CTRL_ARE_LSB +: 2] == GCSE_ARE_ON);
    assign legacy = ctrl_q[GCSE_CTRL_LEGACY];
    assign rev13 = ctrl_q[GCSE_CTRL_REV13];
    // dword-only device: low address or length bits must be zero
    assign gran_bad = cmd_i.desc_check && ctrl_q[GCSE_CTRL_DWORD] &&
        ((cmd_i.desc_addr_lo != GCSE_DWORD_MASK) || (cmd_i.desc_len_lo != GCSE_DWORD_MASK));
    // zero on a keep-alive transport, or over the transport limit
    assign ka_bad = cmd_i.ka_set &&
        ((ctrl_q[GCSE_CTRL_KA_REQ] && cmd_i.ka_value == 16'h0000) ||
         (cmd_i.ka_value > GCSE_KATO_MAX));

    // priority encoder, first matching condition wins
    always_comb begin
        enc_d.code = GCSE_SC_SUCCESS;
        enc_d.dnr = 1'b0;
        if (cmd_i.preempted && cmd_i.reservation_acquire_action == GCSE_RACQ_PREEMPT_ABORT) begin
            enc_d.code = GCSE_SC_PREEMPT_ABORT;
        end else if (cmd_i.ka_expired) begin
            enc_d.code = GCSE_SC_KA_EXPIRED;
        end else if (ctrl_q[GCSE_CTRL_SAN_FAIL] && cmd_i.san_forbidden) begin
            enc_d.code = GCSE_SC_SAN_FAILED;
            enc_d.dnr = 1'b1;
        end else if (ctrl_q[GCSE_CTRL_SAN_BUSY] && cmd_i.san_forbidden) begin
            enc_d.code = GCSE_SC_SAN_BUSY;
        end else if (cmd_i.denied && cmd_i.media_access) begin
            enc_d.code = media_denied_code_i;
            enc_d.dnr = 1'b1;
        end else if (cmd_i.denied) begin
            enc_d.code = GCSE_SC_OP_DENIED;
            enc_d.dnr = 1'b1;
        end else if (cmd_i.wr_protected) begin
            enc_d.code = GCSE_SC_WR_PROT;
            enc_d.dnr = 1'b1;
        end else if (cmd_i.hostid_mixed) begin
            enc_d.code = GCSE_SC_HOSTID_FMT;
            enc_d.dnr = 1'b1;
        end else if (ka_bad) begin
            enc_d.code = GCSE_SC_KA_INVALID;
            enc_d.dnr = 1'b1;
        end else if (cmd_i.cmb_queue_bad && (!rev13 || cmd_i.is_sanitize)) begin
            enc_d.code = GCSE_SC_CMB_QUEUE;
            enc_d.dnr = 1'b1;
        end else if (cmd_i.offset_bad) begin
            enc_d.code = GCSE_SC_DESC_OFFSET;
            enc_d.dnr = 1'b1;
        end else if (gran_bad) begin
            enc_d.code = legacy ? GCSE_SC_OP_DENIED : GCSE_SC_GRAN;
            enc_d.dnr = 1'b1;
        end else if (cmd_i.transient) begin
            enc_d.code = GCSE_SC_TRANSIENT;
        end else if (cmd_i.interrupted && are_on) begin
            enc_d.code = GCSE_SC_INTERRUPTED;
            enc_d.dnr = 1'b0;
        end else if (cmd_i.interrupted) begin
            // retry not enabled: report as an internal error instead
            enc_d.code = GCSE_SC_INTERNAL;
        end else begin
            // css and vendor codes pass through
            enc_d.code = cmd_i.other_code;
        end
        // any reserved value is replaced, never emitted
        if (gcse_is_reserved(enc_d.code)) begin
            enc_d.code = GCSE_SC_INTERNAL;
            enc_d.dnr = 1'b0;
        end
    end

    // completion status register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sts_q <= '0;
            sts_valid_q <= 1'b0;
        end else begin
            sts_valid_q <= cmd_valid_i;
            if (cmd_valid_i) begin
                sts_q <= enc_d;
            end
        end
    end
    assign sts_valid_o = sts_valid_q;
    assign sts_o = sts_q;

    // completion counters
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 16'h0000;
            intr_cnt_q <= 16'h0000;
        end else if (sts_valid_q) begin
            cnt_q <= cnt_q + 16'h0001;
            if (sts_q.code == GCSE_SC_INTERRUPTED) begin
                intr_cnt_q <= intr_cnt_q + 16'h0001;
            end
        end
    end

    // write channel capture, address and data in either order
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end else if (aw_have_q && w_have_q) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end else if (aw_have_q && w_have_q) begin
                w_have_q <= 1'b0;
            end
        end
    end
    assign s_axi_awready_o = !aw_have_q && !bvalid_q;
    assign s_axi_wready_o = !w_have_q && !bvalid_q;

    // control register write and write response
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= GCSE_CTRL_RESET;
            bvalid_q <= 1'b0;
            bresp_q <= GCSE_RESP_OKAY;
        end else begin
            if (aw_have_q && w_have_q) begin
                bvalid_q <= 1'b1;
                if (aw_addr_q[7:2] == GCSE_REG_CTRL[7:2]) begin
                    bresp_q <= GCSE_RESP_OKAY;
                    if (w_strb_q[0]) begin
                        ctrl_q <= w_data_q[7:0];
                    end
                end else if (aw_addr_q[7:2] == GCSE_REG_STATUS[7:2] ||
                             aw_addr_q[7:2] == GCSE_REG_COUNT[7:2] ||
                             aw_addr_q[7:2] == GCSE_REG_LAST[7:2]) begin
                    // read-only registers ignore writes
                    bresp_q <= GCSE_RESP_OKAY;
                end else begin
                    bresp_q <= GCSE_RESP_SLVERR;
                end
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;

    // read channel
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= GCSE_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_q <= 1'b1;
            rresp_q <= GCSE_RESP_OKAY;
            case (s_axi_araddr_i[7:2])
                GCSE_REG_CTRL[7:2]: rdata_q <= {24'h00_0000, ctrl_q};
                GCSE_REG_STATUS[7:2]: rdata_q <= {23'h00_0000, sts_q};
                GCSE_REG_COUNT[7:2]: rdata_q <= {16'h0000, cnt_q};
                GCSE_REG_LAST[7:2]: rdata_q <= {16'h0000, intr_cnt_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= GCSE_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
endmodule : gcse_encoder

//--- gcse_host_model.sv
// Purpose: host that submits commands and reads completions
// Assumes: status answers one cycle after the command pulse
// Notes: applies the host retry policy
`timescale 1ns/100ps
module gcse_host_model (
    input wire logic clk_i,
    output logic cmd_valid_o,
    output gcse_pkg::gcse_cmd_type cmd_o,
    input wire logic sts_valid_i,
    input wire gcse_pkg::gcse_status_type sts_i
);
    import gcse_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // one pulse, status taken on the following cycle
    task automatic submit(input gcse_cmd_type c, output gcse_status_type s);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= ~c; // stale fields never left showing
        @(negedge clk_i);
        s = sts_valid_i ? sts_i : '1; // missing answer reads as all ones
    endtask : submit
    // submit with retries for interrupted and transient results
    task automatic issue(input gcse_cmd_type c, output gcse_status_type s);
        int n;
        submit(c, s);
        if (s.code == 8'h21) submit(c, s);
        for (n = 1; n < 4 && s.code == 8'h22; n++) submit(c, s);
    endtask : issue
endmodule : gcse_host_model

//--- gcse_pkg.sv
// Purpose: constants and carriers for the generic command status encoder
// Assumes: 32-bit axi4-lite register bus, 125 MHz clock
// Notes: status codes are the upper generic code space
package gcse_pkg;
    // generic status codes
    localparam logic [7:0] GCSE_SC_SUCCESS = 8'h00;
    localparam logic [7:0] GCSE_SC_OP_DENIED = 8'h15;
    localparam logic [7:0] GCSE_SC_DESC_OFFSET = 8'h16;
    localparam logic [7:0] GCSE_SC_RSVD_17 = 8'h17;
    localparam logic [7:0] GCSE_SC_HOSTID_FMT = 8'h18;
    localparam logic [7:0] GCSE_SC_KA_EXPIRED = 8'h19;
    localparam logic [7:0] GCSE_SC_KA_INVALID = 8'h1a;
    localparam logic [7:0] GCSE_SC_PREEMPT_ABORT = 8'h1b;
    localparam logic [7:0] GCSE_SC_SAN_FAILED = 8'h1c;
    localparam logic [7:0] GCSE_SC_SAN_BUSY = 8'h1d;
    localparam logic [7:0] GCSE_SC_GRAN = 8'h1e;
    localparam logic [7:0] GCSE_SC_CMB_QUEUE = 8'h1f;
    localparam logic [7:0] GCSE_SC_WR_PROT = 8'h20;
    localparam logic [7:0] GCSE_SC_INTERRUPTED = 8'h21;
    localparam logic [7:0] GCSE_SC_TRANSIENT = 8'h22;
    localparam logic [7:0] GCSE_SC_RSVD_LO = 8'h23;
    localparam logic [7:0] GCSE_SC_RSVD_HI = 8'h7f;
    localparam logic [7:0] GCSE_SC_CSS_LO = 8'h80;
    localparam logic [7:0] GCSE_SC_CSS_HI = 8'hbf;
    localparam logic [7:0] GCSE_SC_VS_LO = 8'hc0;
    // fallback when an internal code is reserved
    localparam logic [7:0] GCSE_SC_INTERNAL = 8'h06;
    // preempt and abort action code
    localparam logic [2:0] GCSE_RACQ_PREEMPT_ABORT = 3'b010;
    // advanced retry enable value that permits the interrupted code
    localparam logic [1:0] GCSE_ARE_ON = 2'h1;
    // dword granularity mask
    localparam logic [1:0] GCSE_DWORD_MASK = 2'b00;
    // register byte offsets
    localparam logic [7:0] GCSE_REG_CTRL = 8'h00;
    localparam logic [7:0] GCSE_REG_STATUS = 8'h04;
    localparam logic [7:0] GCSE_REG_COUNT = 8'h08;
    localparam logic [7:0] GCSE_REG_LAST = 8'h0c;
    // control field positions
    localparam int GCSE_CTRL_ARE_LSB = 0;
    localparam int GCSE_CTRL_LEGACY = 2;
    localparam int GCSE_CTRL_REV13 = 3;
    localparam int GCSE_CTRL_DWORD = 4;
    localparam int GCSE_CTRL_KA_REQ = 5;
    localparam int GCSE_CTRL_SAN_FAIL = 6;
    localparam int GCSE_CTRL_SAN_BUSY = 7;
    // control reset value: revision 1.3 behaviour, dword granularity
    localparam logic [7:0] GCSE_CTRL_RESET = 8'h18;
    // keep-alive timeout largest legal value
    localparam logic [15:0] GCSE_KATO_MAX = 16'hffff;
    // axi response codes
    localparam logic [1:0] GCSE_RESP_OKAY = 2'b00;
    localparam logic [1:0] GCSE_RESP_SLVERR = 2'b10;

    // one command's fault conditions, sampled with cmd_valid
    typedef struct packed {
        logic denied;          // lacking access rights
        logic media_access;    // command accesses media
        logic offset_bad;      // descriptor offset invalid
        logic hostid_mixed;    // 64/128-bit host ids in use
        logic ka_expired;      // keep-alive timer expired
        logic ka_set;          // command sets keep-alive timeout
        logic [15:0] ka_value; // requested timeout
        logic preempted;       // preempted by reservation acquire
        logic [2:0] reservation_acquire_action;
        logic san_forbidden;   // command not allowed during sanitize
        logic is_sanitize;     // command is a sanitize command
        logic desc_check;      // data-block descriptor present
        logic [1:0] desc_addr_lo;
        logic [1:0] desc_len_lo;
        logic cmb_queue_bad;   // queue in controller_memory_buffer unsupported
        logic wr_protected;    // namespace write protected
        logic interrupted;     // processing interrupted
        logic transient;       // transient transport error
        logic [7:0] other_code; // code from other sources (css / vendor)
    } gcse_cmd_type;

    // completion_entry status fields
    typedef struct packed {
        logic [7:0] code;
        logic dnr;
    } gcse_status_type;
endpackage : gcse_pkg

//--- tb.sv
// Purpose: self-checking bench for the status encoder
// Assumes: 125 MHz clock, register bus driven here
// Notes: each case programs control then issues one command
`timescale 1ns/100ps
module tb;
    import gcse_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid;
    gcse_cmd_type cmd;
    logic [7:0] media_code = 8'h86; // dedicated media denial code
    logic sts_valid;
    gcse_status_type sts;
    logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    int err_count = 0, compares = 0, cyc = 0, exp_cnt = 0;
    always #4 clk_i = ~clk_i;
    gcse_encoder u_gcse_encoder (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .media_denied_code_i(media_code), .sts_valid_o(sts_valid), .sts_o(sts),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i));
    gcse_host_model u_gcse_host_model (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
        .sts_valid_i(sts_valid), .sts_i(sts));
    task automatic end_sim;
        if (err_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_sts(input string n, input gcse_status_type e, input gcse_status_type g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_sts
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        r = 2'b11;
        done = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        // only the bench timeout ends a wait with no response
        while (!done) begin
            @(posedge clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) begin
                r = s_axi_bresp_o;
                s_axi_bready_i <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr
    // read: address held until taken, data at rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        r = 2'b11;
        d = '1;
        done = 1'b0;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        // only the bench timeout ends a wait with no read data
        while (!done) begin
            @(posedge clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) begin
                r = s_axi_rresp_o;
                d = s_axi_rdata_o;
                s_axi_rready_i <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd
    // program control, issue one command, check completion and status register
    task automatic go(input logic [7:0] ct, input gcse_cmd_type c, input logic [7:0] ec,
        input logic ed);
        gcse_status_type s;
        logic [31:0] d;
        logic [1:0] r;
        wr(GCSE_REG_CTRL, {24'h0, ct}, r);
        chk_word("ctrl bresp", 32'h0, {30'h0, r});
        u_gcse_host_model.issue(c, s);
        chk_sts("completion", {ec, ed}, s);
        rd(GCSE_REG_STATUS, d, r);
        chk_word("status reg", {23'h0, ec, ed}, d);
        exp_cnt += 1 + ((ec == 8'h21) ? 1 : 0) + ((ec == 8'h22) ? 3 : 0);
    endtask : go
    initial begin : main
        gcse_cmd_type c;
        logic [31:0] d;
        logic [1:0] r;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(GCSE_REG_CTRL, d, r);
        chk_word("ctrl reset", 32'h0000_0018, d);
        for (int i = 0; i < 25; i++) begin
            c = '0;
            case (i)
                0: begin
                    c.denied = 1'b1;
                    go(8'h18, c, 8'h15, 1'b1);
                end
                1: begin
                    c.denied = 1'b1;
                    c.media_access = 1'b1;
                    go(8'h18, c, 8'h86, 1'b1);
                end
                2: begin
                    c.offset_bad = 1'b1;
                    go(8'h18, c, 8'h16, 1'b1);
                end
                3: begin
                    c.hostid_mixed = 1'b1;
                    go(8'h18, c, 8'h18, 1'b1);
                end
                4: begin
                    c.ka_expired = 1'b1;
                    go(8'h18, c, 8'h19, 1'b0);
                end
                5: begin
                    c.ka_set = 1'b1;
                    go(8'h38, c, 8'h1a, 1'b1);
                end
                6: begin
                    c.preempted = 1'b1;
                    c.reservation_acquire_action = 3'b010;
                    go(8'h18, c, 8'h1b, 1'b0);
                end
                7: begin
                    c.preempted = 1'b1;
                    c.reservation_acquire_action = 3'b001;
                    go(8'h18, c, 8'h00, 1'b0);
                end
                8: begin
                    c.san_forbidden = 1'b1;
                    go(8'h58, c, 8'h1c, 1'b1);
                end
                9: begin
                    c.san_forbidden = 1'b1;
                    go(8'h98, c, 8'h1d, 1'b0);
                end
                10: begin
                    c.desc_check = 1'b1;
                    c.desc_len_lo = 2'b10;
                    go(8'h18, c, 8'h1e, 1'b1);
                end
                11: begin
                    c.desc_check = 1'b1;
                    c.desc_addr_lo = 2'b01;
                    go(8'h1c, c, 8'h15, 1'b1);
                end
                12: begin
                    c.cmb_queue_bad = 1'b1;
                    c.is_sanitize = 1'b1;
                    go(8'h18, c, 8'h1f, 1'b1);
                end
                13: begin
                    c.cmb_queue_bad = 1'b1;
                    go(8'h18, c, 8'h00, 1'b0);
                end
                14: begin
                    c.wr_protected = 1'b1;
                    go(8'h18, c, 8'h20, 1'b1);
                end
                15: begin
                    c.interrupted = 1'b1;
                    go(8'h19, c, 8'h21, 1'b0);
                end
                16: begin
                    c.interrupted = 1'b1;
                    go(8'h18, c, 8'h06, 1'b0);
                end
                17: begin
                    c.interrupted = 1'b1;
                    go(8'h1b, c, 8'h06, 1'b0);
                end
                18: begin
                    c.transient = 1'b1;
                    go(8'h18, c, 8'h22, 1'b0);
                end
                19: begin
                    c.other_code = 8'h85;
                    go(8'h18, c, 8'h85, 1'b0);
                end
                20: begin
                    c.other_code = 8'hc3;
                    go(8'h18, c, 8'hc3, 1'b0);
                end
                21: begin
                    c.other_code = 8'h17;
                    go(8'h18, c, 8'h06, 1'b0);
                end
                // older revision: queue fault reported for any command
                22: begin
                    c.cmb_queue_bad = 1'b1;
                    go(8'h10, c, 8'h1f, 1'b1);
                end
                // byte granularity device: low bits are legal
                23: begin
                    c.desc_check = 1'b1;
                    c.desc_addr_lo = 2'b11;
                    go(8'h08, c, 8'h00, 1'b0);
                end
                default: begin
                    c.other_code = 8'h40;
                    go(8'h1b, c, 8'h06, 1'b0);
                end
            endcase
        end
        rd(GCSE_REG_CTRL, d, r);
        chk_word("ctrl readback", 32'h0000_001b, d);
        rd(GCSE_REG_COUNT, d, r);
        chk_word("completion count", exp_cnt, d);
        rd(GCSE_REG_LAST, d, r);
        chk_word("interrupted count", 32'h0000_0002, d);
        rd(8'h40, d, r);
        chk_word("unmapped rresp", {30'h0, GCSE_RESP_SLVERR}, {30'h0, r});
        chk_word("unmapped rdata", 32'h0, d);
        wr(8'h40, 32'h0000_00ff, r);
        chk_word("unmapped bresp", {30'h0, GCSE_RESP_SLVERR}, {30'h0, r});
        end_sim();
    end
endmodule : tb
